// File: common/sclk_pkg.sv
//=============================================================
// Purpose: constants for the synchronous serial clock output block
// Assumes: classic Wishbone register access, 32-bit data, byte addresses
// Notes:   source ticks mark every edge of the selected usart input clock
//
// Overview of operation
// - sync enable plus master select gives master
// - master select bit 14, one master, resets zero
// - continuous clock clear: clock only around characters
// - continuous clock set: clock runs without pause
// - master clock keeps 50% duty, odd divisors
// - selector 0x2 routes fractional divider clock
// - selector resets to 0x7, no clock
// - writing 0x7 stops the serial clock
// - clock equals input clock over divisor+1
// - pin drives clock only as sync master
// - sync enable bit 11, zero means async
//=============================================================
package sclk_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_CONTROL = 8'h04;
    localparam logic [7:0] OFS_BAUD = 8'h08;
    localparam logic [7:0] OFS_CLKSEL = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // field positions
    localparam int BIT_SYNC_EN = 11;
    localparam int BIT_MASTER = 14;
    localparam int BIT_CC = 8;
    localparam int BIT_ST_RUN = 0;
    localparam int BIT_ST_LEVEL = 1;
    localparam int BIT_ST_PIN = 2;
    localparam int DIV_W = 16;

    // reset values
    localparam logic RST_SYNC_EN = 1'b0;
    localparam logic RST_MASTER = 1'b0;
    localparam logic RST_CC = 1'b0;
    localparam logic [DIV_W-1:0] RST_BAUD = 16'h0000;
    localparam logic RST_SCLK_LEVEL = 1'b0;

    // clock source selector codes
    localparam logic [2:0] SEL_OSC = 3'h0;
    localparam logic [2:0] SEL_MAIN = 3'h1;
    localparam logic [2:0] SEL_FRG = 3'h2;
    localparam logic [2:0] SEL_NONE3 = 3'h3;
    localparam logic [2:0] SEL_OSC_DIV = 3'h4;
    localparam logic [2:0] SEL_NONE7 = 3'h7;
    localparam logic [2:0] RST_CLKSEL = SEL_NONE7;
endpackage

// File: common/sclk_div_if.sv
`timescale 1ns/10ps
//=============================================================
// Purpose: link between register logic and the half-period divider
// Assumes: single clock domain
// Notes:   none
//=============================================================
interface sclk_div_if;
    logic run;
    logic tick;
    logic [sclk_pkg::DIV_W-1:0] divisor;
    logic sclk;

    modport ctrl (output run, output tick, output divisor, input sclk);
    modport div (input run, input tick, input divisor, output sclk);
endinterface

// File: verilog/sclk_divider.sv
`timescale 1ns/10ps
//=============================================================
// Purpose: half-period divider producing the serial clock level
// Assumes: tick marks each edge of the input clock, so a half period of
//          divisor+1 ticks gives exactly 50% duty even for odd divisors
// Notes:   stops at low level whenever run drops
//=============================================================
module sclk_divider (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // divider link
    sclk_div_if.div lnk
);
    logic [sclk_pkg::DIV_W-1:0] cnt_q, cnt_d;
    logic sclk_q, sclk_d;

    // count ticks of one half period, toggle when the half is complete
    always_comb begin
        cnt_d = cnt_q;
        sclk_d = sclk_q;
        if (!lnk.run) begin
            cnt_d = '0;
            sclk_d = sclk_pkg::RST_SCLK_LEVEL;
        end else if (lnk.tick) begin
            // >= guards against a divisor lowered mid-half
            if (cnt_q >= lnk.divisor) begin
                cnt_d = '0;
                sclk_d = !sclk_q;
            end else begin
                cnt_d = cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt_q <= '0;
            sclk_q <= sclk_pkg::RST_SCLK_LEVEL;
        end else begin
            cnt_q <= cnt_d;
            sclk_q <= sclk_d;
        end
    end

    assign lnk.sclk = sclk_q;

    // each half period holds for exactly divisor+1 ticks
    a_half_toggle: assert property (@(posedge clk_sys) disable iff (srst)
        lnk.run && lnk.tick && cnt_q == lnk.divisor |=> sclk_q != $past(sclk_q))
        else $error("serial clock missed its half-period toggle");
    a_half_hold: assert property (@(posedge clk_sys) disable iff (srst)
        lnk.run && !(lnk.tick && cnt_q >= lnk.divisor) |=> $stable(sclk_q))
        else $error("serial clock toggled before the half period ended");
endmodule

// File: verilog/sclk_out.sv
// Local design decisions: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
//=============================================================
// Purpose: serial clock output of a usart in synchronous mode, with
//          mode bits, clock-on-character control and source selector
// Assumes: source tick inputs pulse once per edge of each source clock
// Notes:   unmapped addresses ack with zero read data, writes ignored
//=============================================================
module sclk_out (
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // clock source edge ticks
    input wire logic osc_tick,
    input wire logic main_tick,
    input wire logic fractional_divider_clock_tick,
    input wire logic osc_div_tick,
    // character activity from the usart core
    input wire logic tx_char_active,
    input wire logic rx_char_finishing,
    // serial clock pin
    input wire logic serial_clock_pin_in,
    output logic serial_clock_pin_out,
    output logic serial_clock_pin_oe_n
);
    sclk_div_if lnk ();

    //=========================================================
    // register bus
    //=========================================================
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic synchronous_enable_q, synchronous_enable_d;
    logic master_select_q, master_select_d;
    logic continuous_clock_q, continuous_clock_d;
    logic [sclk_pkg::DIV_W-1:0] baud_divisor_q, baud_divisor_d;
    logic [2:0] clksel_q, clksel_d;
    logic wr_en;
    logic usart_input_clock_tick;
    logic src_valid;
    logic sync_master;
    logic run;

    // a write lands in the cycle the ack is raised
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;

    // next values of the registers and the bus answer
    always_comb begin
        ack_d = wb_cyc_i && wb_stb_i && !ack_q;
        synchronous_enable_d = synchronous_enable_q;
        master_select_d = master_select_q;
        continuous_clock_d = continuous_clock_q;
        baud_divisor_d = baud_divisor_q;
        clksel_d = clksel_q;
        rdat_d = 32'h0000_0000;
        if (wr_en) begin
            unique case (wb_adr_i)
                sclk_pkg::OFS_CONFIG: begin
                    if (wb_sel_i[1]) begin
                        synchronous_enable_d = wb_dat_i[sclk_pkg::BIT_SYNC_EN];
                        master_select_d = wb_dat_i[sclk_pkg::BIT_MASTER];
                    end
                end
                sclk_pkg::OFS_CONTROL: begin
                    if (wb_sel_i[1]) begin
                        continuous_clock_d = wb_dat_i[sclk_pkg::BIT_CC];
                    end
                end
                sclk_pkg::OFS_BAUD: begin
                    if (wb_sel_i[0]) begin
                        baud_divisor_d[7:0] = wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        baud_divisor_d[15:8] = wb_dat_i[15:8];
                    end
                end
                sclk_pkg::OFS_CLKSEL: begin
                    if (wb_sel_i[0]) begin
                        clksel_d = wb_dat_i[2:0];
                    end
                end
                default: begin
                end
            endcase
        end
        if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q) begin
            unique case (wb_adr_i)
                sclk_pkg::OFS_CONFIG: begin
                    rdat_d[sclk_pkg::BIT_SYNC_EN] = synchronous_enable_q;
                    rdat_d[sclk_pkg::BIT_MASTER] = master_select_q;
                end
                sclk_pkg::OFS_CONTROL: rdat_d[sclk_pkg::BIT_CC] = continuous_clock_q;
                sclk_pkg::OFS_BAUD: rdat_d[15:0] = baud_divisor_q;
                sclk_pkg::OFS_CLKSEL: rdat_d[2:0] = clksel_q;
                sclk_pkg::OFS_STATUS: begin
                    rdat_d[sclk_pkg::BIT_ST_RUN] = run;
                    rdat_d[sclk_pkg::BIT_ST_LEVEL] = lnk.sclk;
                    rdat_d[sclk_pkg::BIT_ST_PIN] = serial_clock_pin_in;
                end
                default: rdat_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            synchronous_enable_q <= sclk_pkg::RST_SYNC_EN;
            master_select_q <= sclk_pkg::RST_MASTER;
            continuous_clock_q <= sclk_pkg::RST_CC;
            baud_divisor_q <= sclk_pkg::RST_BAUD;
            clksel_q <= sclk_pkg::RST_CLKSEL;
        end else begin
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            synchronous_enable_q <= synchronous_enable_d;
            master_select_q <= master_select_d;
            continuous_clock_q <= continuous_clock_d;
            baud_divisor_q <= baud_divisor_d;
            clksel_q <= clksel_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    //=========================================================
    // clock source selection and run control
    //=========================================================
    // reserved and none codes give no ticks, so the divider cannot advance
    always_comb begin
        usart_input_clock_tick = 1'b0;
        src_valid = 1'b1;
        unique case (clksel_q)
            sclk_pkg::SEL_OSC: usart_input_clock_tick = osc_tick;
            sclk_pkg::SEL_MAIN: usart_input_clock_tick = main_tick;
            sclk_pkg::SEL_FRG: usart_input_clock_tick = fractional_divider_clock_tick;
            sclk_pkg::SEL_OSC_DIV: usart_input_clock_tick = osc_div_tick;
            default: src_valid = 1'b0;
        endcase
    end

    // slave or async mode never clocks the pin
    assign sync_master = synchronous_enable_q && master_select_q;
    // clock on character unless continuous clock is set
    assign run = sync_master && src_valid &&
                 (continuous_clock_q || tx_char_active || rx_char_finishing);

    assign lnk.run = run;
    assign lnk.tick = usart_input_clock_tick;
    assign lnk.divisor = baud_divisor_q;

    sclk_divider u_div (
        .clk_sys(clk_sys),
        .srst(srst),
        .lnk(lnk)
    );

    //=========================================================
    // serial clock pin
    //=========================================================
    // pin output is held low and the pin is released whenever it is not a clock output
    assign serial_clock_pin_out = sync_master ? lnk.sclk : 1'b0;
    assign serial_clock_pin_oe_n = !sync_master;

    //=========================================================
    // checks
    //=========================================================
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    a_sel_reset: assert property ($fell(srst) |-> clksel_q == 3'h7 && !run)
        else $error("selector not at no-source after reset");
    a_mode_reset: assert property ($fell(srst) |-> serial_clock_pin_oe_n && !master_select_q)
        else $error("pin driven or master set after reset");
    a_master_drive: assert property (wr_en && wb_adr_i == sclk_pkg::OFS_CONFIG && wb_sel_i[1]
        && wb_dat_i[sclk_pkg::BIT_SYNC_EN] && wb_dat_i[sclk_pkg::BIT_MASTER]
        |=> !serial_clock_pin_oe_n)
        else $error("sync master write did not drive the pin");
    a_async_quiet: assert property (!synchronous_enable_q |-> serial_clock_pin_oe_n
        && !serial_clock_pin_out)
        else $error("async mode produced a clock");
    a_slave_quiet: assert property (!master_select_q |-> serial_clock_pin_oe_n
        && !serial_clock_pin_out)
        else $error("slave mode drove the clock pin");
    a_stop_sel7: assert property (wr_en && wb_adr_i == sclk_pkg::OFS_CLKSEL && wb_sel_i[0]
        && wb_dat_i[2:0] == sclk_pkg::SEL_NONE7 |-> ##2 !lnk.sclk && !run)
        else $error("selecting no source did not stop the clock");
    a_frg_route: assert property (clksel_q == sclk_pkg::SEL_FRG |-> usart_input_clock_tick
        == fractional_divider_clock_tick)
        else $error("fractional divider clock not routed");
    a_reserved_none: assert property (clksel_q == 3'h5 || clksel_q == 3'h6
        || clksel_q == 3'h3 |-> !run ##1 !lnk.sclk)
        else $error("reserved selector code produced a clock");
    a_char_only: assert property (!continuous_clock_q && !tx_char_active
        && !rx_char_finishing |-> !run ##1 !lnk.sclk)
        else $error("clock ran with no character activity");
    a_continuous: assert property (sync_master && src_valid && continuous_clock_q
        |-> run)
        else $error("continuous clock paused");

    // the reset code and a written stop code both keep the divider halted
    a_sel_none7: assert property (clksel_q == sclk_pkg::SEL_NONE7 |-> !run)
        else $error("no-source selector left the clock running");

    // a dropped run forces the idle level at once rather than finishing the half
    a_stop_low: assert property (!run |=> !lnk.sclk)
        else $error("serial clock not idle after run dropped");

    // whenever the pin is driven it carries the divider level and nothing else
    a_pin_follow: assert property (!serial_clock_pin_oe_n |-> serial_clock_pin_out == lnk.sclk)
        else $error("driven pin does not carry the serial clock");
endmodule

// File: test/sclk_consumer.sv
//=============================================================
// Purpose: far-side clock consumer that times each serial clock half
// Assumes: one sample per clk_sys edge is enough resolution
// Notes:   drives a changing level whenever the device releases the pin
//=============================================================
`timescale 1ns/10ps
module sclk_consumer (
    // clock
    input wire logic clk_sys,
    // pin level on the wire and device release flag
    input wire logic sclk_lvl,
    input wire logic released,
    // own drive and measurements
    output logic drv_lvl = 1'b0,
    output int hi_len = 0,
    output int lo_len = 0,
    output int rises = 0
);
    logic prev_q = 1'b0;
    int run_q = 0;

    // a half is stored only once it has ended, so a half still in progress never shows
    always @(posedge clk_sys) begin
        prev_q <= sclk_lvl;
        run_q <= (sclk_lvl !== prev_q) ? 1 : run_q + 1;
        if (sclk_lvl !== prev_q && prev_q === 1'b1)
            hi_len <= run_q;
        if (sclk_lvl !== prev_q && prev_q === 1'b0)
            lo_len <= run_q;
        if (sclk_lvl === 1'b1 && prev_q === 1'b0)
            rises <= rises + 1;
        // toggling pattern: a released pin must never look like a held level
        drv_lvl <= released ? ~drv_lvl : 1'b0;
    end
endmodule

// File: test/sclk_out_test.sv
//=============================================================
// Purpose: self-checking bench for the serial clock output block
// Assumes: source ticks every 1, 2, 3, 4 cycles for codes 0, 1, 2, 4
// Notes:   half periods are timed on the wire by the consumer model
//=============================================================
`timescale 1ns/10ps
module sclk_out_test;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, tx = 1'b0, rx = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0, tk = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic ack, pin_out, oe_n, pin, drv;
    int hi_len, lo_len, rises, errors = 0, comparisons = 0, cnt = 0;

    // wire level: device drives while enabled, consumer otherwise
    assign pin = oe_n ? drv : pin_out;
    always #2 clk_sys = ~clk_sys;

    // source edge ticks, a different spacing per source
    always @(posedge clk_sys) begin
        cnt <= cnt + 1;
        for (int i = 0; i < 4; i++) begin
            tk[i] <= (cnt % (i + 1)) == 0;
        end
    end

    sclk_out u_sclk_out (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .osc_tick(tk[0]), .main_tick(tk[1]),
        .fractional_divider_clock_tick(tk[2]), .osc_div_tick(tk[3]),
        .tx_char_active(tx), .rx_char_finishing(rx), .serial_clock_pin_in(pin),
        .serial_clock_pin_out(pin_out), .serial_clock_pin_oe_n(oe_n));
    sclk_consumer u_sclk_consumer (.clk_sys(clk_sys), .sclk_lvl(pin), .released(oe_n),
        .drv_lvl(drv), .hi_len(hi_len), .lo_len(lo_len), .rises(rises));

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // classic single cycle; waits for ack with no assumed latency
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = dat_o;
        if (n >= 50)
            cmp(1'b0, 1'b1, "no ack");
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_sys);
    endtask

    // reference: half period in cycles, zero where no source runs
    function automatic int half(input int code, input int d);
        int sp[8] = '{1, 2, 3, 0, 4, 0, 0, 0};
        return sp[code] * (d + 1);
    endfunction

    task automatic cfg(input int d, input logic cont, input logic [2:0] sc, input logic [31:0] md);
        wb(1'b1, 8'h08, d, rdat);
        wb(1'b1, 8'h04, {23'h0, cont, 8'h00}, rdat);
        wb(1'b1, 8'h00, md, rdat);
        wb(1'b1, 8'h0C, {29'h0, sc}, rdat);
    endtask

    // long enough for several fresh halves after any change
    task automatic run_chk(input int exp);
        int r0;
        r0 = rises;
        repeat (8 * exp + 40) @(posedge clk_sys);
        if (exp == 0) begin
            cmp(rises - r0, 0, "edges");
            cmp(pin_out, 0, "idle");
        end else begin
            cmp(hi_len, exp, "high");
            cmp(lo_len, exp, "low");
            cmp((rises - r0) > 2, 1, "running");
        end
    endtask

    task automatic close_out;
        if (errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk_sys);
        errors++;
        close_out;
    end

    initial begin
        int d;
        logic [31:0] v;
        logic [2:0] code[8] = '{3'h3, 3'h0, 3'h5, 3'h1, 3'h6, 3'h2, 3'h4, 3'h7};
        logic [7:0] ofs[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14};
        logic [31:0] rst_v[5] = '{32'h0, 32'h0, 32'h0, 32'h7, 32'h0};
        void'($urandom(32'hBA37));
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        // reset values, the unmapped place included
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, ofs[i], 32'h0, rdat);
            cmp(rdat, rst_v[i], "reset");
        end
        cmp(oe_n, 1'b1, "reset oe");
        wb(1'b1, 8'h14, $urandom, rdat);
        wb(1'b0, 8'h14, 32'h0, rdat);
        cmp(rdat, 32'h0, "unmapped");
        // only sync enable together with master select drives the pin
        for (int m = 1; m < 4; m++) begin
            v = ($urandom & ~32'h4800) | (m[0] << 11) | (m[1] << 14);
            wb(1'b1, 8'h00, v, rdat);
            wb(1'b0, 8'h00, 32'h0, rdat);
            cmp(rdat, v & 32'h4800, "config");
            cmp(oe_n, m != 3, "drive");
        end
        // every selector code; 7 right after a running code stops the clock
        for (int i = 0; i < 8; i++) begin
            d = $urandom % 6;
            cfg(d, 1'b1, code[i], 32'h4800);
            run_chk(half(code[i], d));
        end
        // clock on character: idle, then transmit, then receive completion
        d = $urandom % 6;
        for (int m = 0; m < 3; m++) begin
            tx <= (m == 1);
            rx <= (m == 2);
            if (m == 0)
                cfg(d, 1'b0, 3'h2, 32'h4800);
            run_chk(m == 0 ? 0 : half(2, d));
        end
        // status while receive completion keeps the clock going: pin carries the level
        wb(1'b0, sclk_pkg::OFS_STATUS, 32'h0, rdat);
        cmp(rdat[sclk_pkg::BIT_ST_RUN], 1'b1, "status run");
        cmp(rdat[sclk_pkg::BIT_ST_PIN], rdat[sclk_pkg::BIT_ST_LEVEL], "status pin");
        rx <= 1'b0;
        // slave with a source running still produces no clock
        cfg(d, 1'b1, 3'h2, 32'h0800);
        repeat (40) @(posedge clk_sys);
        cmp(pin_out, 1'b0, "slave");
        cmp(oe_n, 1'b1, "slave oe");
        wb(1'b0, sclk_pkg::OFS_STATUS, 32'h0, rdat);
        cmp(rdat[1:0], 2'b00, "slave status");
        close_out;
    end
endmodule
